// ==== mac_dma_monitor.sv ====
// checker: bus, reply mover and acknowledgement timing at the register block ports
`timescale 1ns/1ps
module mac_dma_monitor
	import mac_dma_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_ack_o,
	input wire logic [WORD_W-1:0] wb_dat_o,
	input wire logic              ack_valid_i,
	input wire logic              ack_match_o,
	input wire logic              mem_req_o,
	input wire logic [WORD_W-1:0] mem_addr_o,
	input wire logic              mem_ack_i,
	input wire logic [BYTE_W-1:0] mem_rdata_i,
	input wire logic              txq_valid_o,
	input wire logic [BYTE_W-1:0] txq_data_o,
	input wire logic              txq_ready_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_fetch;
		mem_req_o && mem_ack_i;
	endsequence
	sequence s_push;
		txq_valid_o && txq_data_o == $past(mem_rdata_i);
	endsequence

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == ZERO_WORD)
		else $error("read data not zero outside ack");
	a_match_cause: assert property (ack_match_o |-> $past(ack_valid_i))
		else $error("sequence match without received acknowledgement");
	a_fetch_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("memory request dropped or address moved");
	a_push_hold: assert property (txq_valid_o && !txq_ready_i |=> txq_valid_o && $stable(txq_data_o))
		else $error("queue byte dropped or changed");
	a_fetch_push: assert property (s_fetch |=> s_push)
		else $error("fetched byte not offered to queue");
	a_one_phase: assert property (!(txq_valid_o && mem_req_o))
		else $error("fetch overlaps push");
endmodule // mac_dma_monitor

bind mac_dma_regs mac_dma_monitor i_mac_dma_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_dat_o, .ack_valid_i, .ack_match_o, .mem_req_o, .mem_addr_o, .mem_ack_i,
	.mem_rdata_i, .txq_valid_o, .txq_data_o, .txq_ready_i);

// ==== mac_dma_pkg.sv ====
// package: register map, field layout and interrupt bits of the dma length and level block
package mac_dma_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] OFS_POLL_PTR = 8'h88;
	localparam logic [7:0] OFS_TX_LEN   = 8'h8C;
	localparam logic [7:0] OFS_TX_SEQ   = 8'h90;
	localparam logic [7:0] OFS_RX_THR   = 8'h94;
	localparam logic [7:0] OFS_RX_CNT   = 8'h98;
	localparam logic [7:0] OFS_IRQ_STAT = 8'hC0;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'hC4;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hC8;
	localparam logic [7:0] OFS_CTRL     = 8'hCC;

	// field widths
	localparam int WORD_W    = 32;
	localparam int LEN_W     = 15;
	localparam int STD_LEN_W = 7;
	localparam int SEQ_W     = 7;
	localparam int LVL_W     = 16;
	localparam int IRQ_W     = 16;
	localparam int BYTE_W    = 8;
	localparam int SEL_W     = 4;

	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ACK  = 3;
	localparam int IRQ_LVL  = 9;

	// control register bits
	localparam int CTRL_STD   = 0;
	localparam int CTRL_ARMED = 1;
	localparam int CTRL_BUSY  = 2;

	localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [LVL_W-1:0]  LVL_MAX   = 16'hFFFF;
	localparam logic [LVL_W-1:0]  LVL_ZERO  = 16'h0000;
	localparam logic [LVL_W-1:0]  LVL_ONE   = 16'h0001;
endpackage

// ==== mac_dma_regs.sv ====
// register block: poll reply pointer, transmit length and sequence, receive level interrupt
//
// Functional notes
// RULE1 - pointer write arms reply to data request
// RULE2 - reply copies memory to queue bytewise
// RULE3 - device never alters the stored pointer
// RULE4 - length counts bytes incl. checksum, no header
// RULE5 - standard mode uses low seven length bits
// RULE6 - software sets length before pointer write
// RULE7 - seven-bit sequence validates received acknowledgements
// RULE8 - software sets sequence before pointer write
// RULE9 - level interrupt when delivered bytes reach threshold
// RULE10 - threshold rewrites mid-packet re-evaluate, re-interrupt
// RULE11 - count register reads delivered bytes, read-only
// RULE12 - level sets status bit nine, write-one clears
// RULE13 - reserved bits read zero, writes ignored
`timescale 1ns/1ps
module mac_dma_regs
	import mac_dma_pkg::*;
#(
	parameter int ADR_W = 8
)(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [SEL_W-1:0]  wb_sel_i,
	input  wire logic [WORD_W-1:0] wb_dat_i,
	output logic [WORD_W-1:0]      wb_dat_o,
	output logic                   wb_ack_o,
	// remote data request and acknowledgement check
	input  wire logic              poll_request_i,
	input  wire logic              ack_valid_i,
	input  wire logic [SEQ_W-1:0]  ack_seq_i,
	output logic                   ack_match_o,
	// receive dma progress
	input  wire logic              rx_start_i,
	input  wire logic              rx_byte_i,
	// memory read port of the transmit dma
	output logic                   mem_req_o,
	output logic [WORD_W-1:0]      mem_addr_o,
	input  wire logic              mem_ack_i,
	input  wire logic [BYTE_W-1:0] mem_rdata_i,
	// transmit queue
	output logic                   txq_valid_o,
	output logic [BYTE_W-1:0]      txq_data_o,
	input  wire logic              txq_ready_i,
	output logic [LEN_W-1:0]       tx_len_o,
	output logic                   irq_o
);
	if (ADR_W < 8) begin : g_check
		$error("ADR_W must be at least 8");
	end
	// the field layout must fit one bus word and one status register
	if (LEN_W > WORD_W || SEQ_W > WORD_W || LVL_W > WORD_W) begin : g_field_check
		$error("register fields wider than the bus word");
	end
	if (STD_LEN_W > LEN_W) begin : g_std_check
		$error("standard length wider than the length field");
	end
	if (IRQ_LVL >= IRQ_W || IRQ_ACK >= IRQ_W || IRQ_DONE >= IRQ_W) begin : g_irq_check
		$error("status bit outside the status register");
	end
	if (SEL_W * BYTE_W != WORD_W) begin : g_lane_check
		$error("byte lanes do not cover the bus word");
	end

	typedef struct packed {
		logic [WORD_W-1:0] poll_ptr;
		logic [LEN_W-1:0]  tx_len;
		logic [SEQ_W-1:0]  tx_seq;
		logic [LVL_W-1:0]  rx_thr;
		logic [LVL_W-1:0]  rx_cnt;
		logic              lvl_reached;
		logic [IRQ_W-1:0]  irq_stat;
		logic [IRQ_W-1:0]  irq_mask;
		logic              std_mode;
		logic              armed;
		logic              start;
		logic [LEN_W-1:0]  launch_len;
		logic              ack;
		logic [WORD_W-1:0] rdat;
		logic              ack_match;
	} regs_t;

	localparam regs_t REGS_RESET = '0;

	regs_t st;
	regs_t next_st;

	logic mover_busy;
	logic mover_done;

	// byte-lane merge of a bus write into a stored word
	function automatic logic [WORD_W-1:0] merge(
		input logic [WORD_W-1:0] old,
		input logic [WORD_W-1:0] wd,
		input logic [SEL_W-1:0]  sel
	);
		logic [WORD_W-1:0] res;
		res = old;
		for (int i = 0; i < SEL_W; i++) begin
			if (sel[i]) begin
				res[i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
			end
		end
		return res;
	endfunction

	// address decode: every bus address bit above the lowest two must match, upper bits included
	function automatic logic hit(
		input logic [ADR_W-1:0] adr,
		input logic [7:0]       ofs
	);
		logic [ADR_W-1:0] full;
		full = ADR_W'(ofs);
		return adr[ADR_W-1:2] == full[ADR_W-1:2];
	endfunction

	// the standard mode ignores the upper length bits
	function automatic logic [LEN_W-1:0] eff_len(
		input logic [LEN_W-1:0] len,
		input logic             std
	);
		logic [LEN_W-1:0] res;
		res = len;
		if (std) begin
			res = {{(LEN_W-STD_LEN_W){1'b0}}, len[STD_LEN_W-1:0]}; // [RULE5]
		end
		return res;
	endfunction

	// zero extension to a bus word, so reserved bits always read as zero
	function automatic logic [WORD_W-1:0] widen_len(
		input logic [LEN_W-1:0] val
	);
		return WORD_W'(val); // [RULE13]
	endfunction

	function automatic logic [WORD_W-1:0] widen_seq(
		input logic [SEQ_W-1:0] val
	);
		return WORD_W'(val); // [RULE13]
	endfunction

	function automatic logic [WORD_W-1:0] widen_lvl(
		input logic [LVL_W-1:0] val
	);
		return WORD_W'(val); // [RULE13]
	endfunction

	function automatic logic [WORD_W-1:0] widen_irq(
		input logic [IRQ_W-1:0] val
	);
		return WORD_W'(val); // [RULE13]
	endfunction

	// control word: only the mode bit is stored, armed and busy just report
	function automatic logic [WORD_W-1:0] ctrl_word(
		input logic std,
		input logic arm,
		input logic busy
	);
		logic [WORD_W-1:0] res;
		res = ZERO_WORD;
		res[CTRL_STD]   = std;
		res[CTRL_ARMED] = arm;
		res[CTRL_BUSY]  = busy;
		return res;
	endfunction

	// threshold zero keeps the level interrupt off
	function automatic logic lvl_hit(
		input logic [LVL_W-1:0] cnt,
		input logic [LVL_W-1:0] thr
	);
		return (thr != LVL_ZERO) && (cnt >= thr);
	endfunction

	// sticky status: an event in the clearing cycle must not be lost
	function automatic logic [IRQ_W-1:0] sticky(
		input logic [IRQ_W-1:0] old,
		input logic [IRQ_W-1:0] clear,
		input logic [IRQ_W-1:0] ev
	);
		return (old & ~clear) | ev;
	endfunction

	logic              acc;
	logic              wr;
	logic              rd;
	logic [WORD_W-1:0] wword;
	logic [IRQ_W-1:0]  events;
	logic [IRQ_W-1:0]  clr;
	logic [LVL_W-1:0]  cnt_base;
	logic              lvl_now;

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.ack_match = 1'b0;
		events = '0;
		clr = '0;
		wword = ZERO_WORD;
		acc = wb_cyc_i && wb_stb_i && !st.ack;
		wr = acc && wb_we_i;
		rd = acc && !wb_we_i;
		next_st.ack = acc;

		// reply launch: pointer and length already stable in registers
		if (st.armed && poll_request_i && !mover_busy && !st.start) begin
			next_st.start = 1'b1; // [RULE1]
			next_st.armed = 1'b0;
			next_st.launch_len = eff_len(st.tx_len, st.std_mode); // [RULE4] [RULE6]
		end

		// register writes; reserved bits are dropped by slicing
		if (wr) begin
			if (hit(wb_adr_i, OFS_POLL_PTR)) begin
				next_st.poll_ptr = merge(st.poll_ptr, wb_dat_i, wb_sel_i);
				next_st.armed = 1'b1; // [RULE1]
			end
			if (hit(wb_adr_i, OFS_TX_LEN)) begin
				wword = merge(widen_len(st.tx_len), wb_dat_i, wb_sel_i);
				next_st.tx_len = wword[LEN_W-1:0]; // [RULE13]
			end
			if (hit(wb_adr_i, OFS_TX_SEQ)) begin
				wword = merge(widen_seq(st.tx_seq), wb_dat_i, wb_sel_i);
				next_st.tx_seq = wword[SEQ_W-1:0]; // [RULE13]
			end
			if (hit(wb_adr_i, OFS_RX_THR)) begin
				wword = merge(widen_lvl(st.rx_thr), wb_dat_i, wb_sel_i);
				next_st.rx_thr = wword[LVL_W-1:0]; // [RULE10]
			end
			if (hit(wb_adr_i, OFS_IRQ_CLR)) begin
				wword = merge(ZERO_WORD, wb_dat_i, wb_sel_i);
				clr = wword[IRQ_W-1:0]; // [RULE12]
			end
			if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
				wword = merge(widen_irq(st.irq_mask), wb_dat_i, wb_sel_i);
				next_st.irq_mask = wword[IRQ_W-1:0];
			end
			if (hit(wb_adr_i, OFS_CTRL)) begin
				wword = merge(ctrl_word(st.std_mode, 1'b0, 1'b0), wb_dat_i, wb_sel_i);
				next_st.std_mode = wword[CTRL_STD];
			end
		end

		// register reads; unmapped addresses answer with zero
		next_st.rdat = ZERO_WORD;
		if (rd) begin
			if (hit(wb_adr_i, OFS_POLL_PTR)) begin
				next_st.rdat = st.poll_ptr; // [RULE3]
			end
			if (hit(wb_adr_i, OFS_TX_LEN)) begin
				next_st.rdat = widen_len(st.tx_len); // [RULE13]
			end
			if (hit(wb_adr_i, OFS_TX_SEQ)) begin
				next_st.rdat = widen_seq(st.tx_seq); // [RULE13]
			end
			if (hit(wb_adr_i, OFS_RX_THR)) begin
				next_st.rdat = widen_lvl(st.rx_thr);
			end
			if (hit(wb_adr_i, OFS_RX_CNT)) begin
				next_st.rdat = widen_lvl(st.rx_cnt); // [RULE11]
			end
			if (hit(wb_adr_i, OFS_IRQ_STAT)) begin
				next_st.rdat = widen_irq(st.irq_stat);
				clr = st.irq_stat; // read clears what it returned
			end
			if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
				next_st.rdat = widen_irq(st.irq_mask);
			end
			if (hit(wb_adr_i, OFS_CTRL)) begin
				next_st.rdat = ctrl_word(st.std_mode, st.armed, mover_busy || st.start);
			end
		end

		// acknowledgement check against the sequence of the sent packet
		if (ack_valid_i && ack_seq_i == st.tx_seq) begin
			next_st.ack_match = 1'b1; // [RULE7] [RULE8]
			events[IRQ_ACK] = 1'b1;
		end

		if (mover_done) begin
			events[IRQ_DONE] = 1'b1;
		end

		// delivered byte count, saturating so it never wraps below the threshold
		cnt_base = st.rx_cnt;
		if (rx_start_i) begin
			cnt_base = LVL_ZERO;
		end
		next_st.rx_cnt = cnt_base;
		if (rx_byte_i && cnt_base != LVL_MAX) begin
			next_st.rx_cnt = cnt_base + LVL_ONE; // [RULE11]
		end

		// edge of the reached condition; a raised threshold re-arms it
		lvl_now = lvl_hit(st.rx_cnt, st.rx_thr); // [RULE9]
		if (lvl_now && !st.lvl_reached) begin
			events[IRQ_LVL] = 1'b1; // [RULE9] [RULE10]
		end
		next_st.lvl_reached = lvl_now; // [RULE10]

		// a new event wins over a clear in the same cycle
		next_st.irq_stat = sticky(st.irq_stat, clr, events); // [RULE12]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= REGS_RESET;
		end else begin
			st <= next_st;
		end
	end

	mac_dma_tx_mover u_mover (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.start_i     (st.start),
		.src_addr_i  (st.poll_ptr),
		.len_i       (st.launch_len),
		.mem_req_o   (mem_req_o),
		.mem_addr_o  (mem_addr_o),
		.mem_ack_i   (mem_ack_i),
		.mem_rdata_i (mem_rdata_i),
		.txq_valid_o (txq_valid_o),
		.txq_data_o  (txq_data_o),
		.txq_ready_i (txq_ready_i),
		.busy_o      (mover_busy),
		.done_o      (mover_done)
	); // [RULE2]

	assign wb_dat_o    = st.rdat;
	assign wb_ack_o    = st.ack;
	assign ack_match_o = st.ack_match;
	assign tx_len_o    = st.launch_len;
	assign irq_o       = |(st.irq_stat & st.irq_mask);
endmodule // mac_dma_regs

// ==== mac_dma_tx_mover.sv ====
// byte mover: copies a block from memory into the transmit queue, one byte per transfer
`timescale 1ns/1ps
module mac_dma_tx_mover
	import mac_dma_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              start_i,
	input  wire logic [WORD_W-1:0] src_addr_i,
	input  wire logic [LEN_W-1:0]  len_i,
	output logic                   mem_req_o,
	output logic [WORD_W-1:0]      mem_addr_o,
	input  wire logic              mem_ack_i,
	input  wire logic [BYTE_W-1:0] mem_rdata_i,
	output logic                   txq_valid_o,
	output logic [BYTE_W-1:0]      txq_data_o,
	input  wire logic              txq_ready_i,
	output logic                   busy_o,
	output logic                   done_o
);
	typedef enum logic [2:0] {
		M_IDLE  = 3'b001,
		M_FETCH = 3'b010,
		M_PUSH  = 3'b100
	} mover_state_t;

	typedef struct packed {
		mover_state_t        fsm;
		logic [WORD_W-1:0]   addr;
		logic [LEN_W-1:0]    left;
		logic [BYTE_W-1:0]   data;
		logic                done;
	} mover_t;

	localparam logic [LEN_W-1:0]  LEN_ZERO = 15'h0000;
	localparam logic [LEN_W-1:0]  LEN_ONE  = 15'h0001;
	localparam logic [WORD_W-1:0] ADDR_ONE = 32'h0000_0001;
	localparam mover_t MOVER_RESET = '{M_IDLE, ZERO_WORD, LEN_ZERO, 8'h00, 1'b0};

	mover_t st;
	mover_t next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		unique case (st.fsm)
			M_IDLE: begin
				if (start_i) begin
					next_st.addr = src_addr_i; // [RULE2]
					next_st.left = len_i; // [RULE4]
					if (len_i == LEN_ZERO) begin
						next_st.done = 1'b1;
					end else begin
						next_st.fsm = M_FETCH;
					end
				end
			end
			M_FETCH: begin
				if (mem_ack_i) begin
					next_st.data = mem_rdata_i; // [RULE2]
					next_st.addr = st.addr + ADDR_ONE;
					next_st.left = st.left - LEN_ONE;
					next_st.fsm  = M_PUSH;
				end
			end
			M_PUSH: begin
				if (txq_ready_i) begin
					if (st.left == LEN_ZERO) begin
						next_st.fsm  = M_IDLE;
						next_st.done = 1'b1;
					end else begin
						next_st.fsm = M_FETCH;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= MOVER_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign mem_req_o   = (st.fsm == M_FETCH);
	assign mem_addr_o  = st.addr;
	assign txq_valid_o = (st.fsm == M_PUSH);
	assign txq_data_o  = st.data;
	assign busy_o      = (st.fsm != M_IDLE);
	assign done_o      = st.done;
endmodule // mac_dma_tx_mover

// ==== tb_top.sv ====
// testbench: register map, poll reply transfer, acknowledgement check and level interrupt
`timescale 1ns/1ps
module tb_top
	import mac_dma_pkg::*;
;
	logic              clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic              wb_we_i = 1'b0, poll_request_i = 1'b0, ack_valid_i = 1'b0;
	logic              rx_start_i = 1'b0, rx_byte_i = 1'b0, mem_ack_i = 1'b0, txq_ready_i = 1'b0;
	logic              wb_ack_o, ack_match_o, mem_req_o, txq_valid_o, irq_o;
	logic [7:0]        wb_adr_i = 8'h00;
	logic [SEL_W-1:0]  wb_sel_i = 4'hF;
	logic [WORD_W-1:0] wb_dat_i = 32'h0, wb_dat_o, mem_addr_o, rd, v;
	logic [SEQ_W-1:0]  ack_seq_i = 7'h00;
	logic [BYTE_W-1:0] mem_rdata_i = 8'h00, txq_data_o;
	logic [LEN_W-1:0]  tx_len_o;
	logic [BYTE_W-1:0] exp_q[$];
	logic [7:0]        ofs[6] = '{OFS_POLL_PTR, OFS_TX_LEN, OFS_TX_SEQ, OFS_RX_THR, OFS_RX_CNT, 8'hF0};
	logic [31:0]       msk[6] = '{32'hFFFF_FFFF, 32'h7FFF, 32'h7F, 32'hFFFF, 32'h0, 32'h0};
	int                failures = 0, total_checks = 0, cycles = 0, i;
	int                seed = 32'h297e77cd;
	localparam int     P_POLL = 0, P_READY = 1, P_START = 2, P_BYTE = 3;

	mac_dma_regs i_mac_dma_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .poll_request_i, .ack_valid_i, .ack_seq_i,
		.ack_match_o, .rx_start_i, .rx_byte_i, .mem_req_o, .mem_addr_o, .mem_ack_i,
		.mem_rdata_i, .txq_valid_o, .txq_data_o, .txq_ready_i, .tx_len_o, .irq_o);

	always #2 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// runaway guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// request held up to the rising edge that samples ack; read data taken there
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// one-cycle strobe on a design input chosen by number
	task automatic pulse(input int which);
		@(posedge clk_i);
		case (which)
			P_POLL:  poll_request_i <= 1'b1;
			P_READY: txq_ready_i <= 1'b1;
			P_START: rx_start_i <= 1'b1;
			default: rx_byte_i <= 1'b1;
		endcase
		@(posedge clk_i);
		poll_request_i <= 1'b0;
		txq_ready_i    <= 1'b0;
		rx_start_i     <= 1'b0;
		rx_byte_i      <= 1'b0;
	endtask

	task automatic reply(input logic [14:0] len, input logic std);
		logic [31:0] ptr;
		int          n;
		ptr = $random(seed);
		n = std ? int'(len[6:0]) : int'(len);
		bus(1'b1, OFS_CTRL, {31'h0, std});
		bus(1'b1, OFS_TX_LEN, {17'h0, len});
		bus(1'b1, OFS_TX_SEQ, 32'($random(seed)));
		bus(1'b1, OFS_POLL_PTR, ptr);
		pulse(P_POLL);
		for (int k = 0; k < n; k++) begin
			@(negedge clk_i);
			while (mem_req_o !== 1'b1) @(negedge clk_i);
			chk(mem_addr_o, ptr + 32'(k));
			bus(1'b0, OFS_POLL_PTR, 32'h0);
			chk(rd, ptr);
			exp_q.push_back(8'($random(seed)));
			@(posedge clk_i);
			mem_ack_i   <= 1'b1;
			mem_rdata_i <= exp_q[$];
			@(posedge clk_i);
			mem_ack_i <= 1'b0;
			@(negedge clk_i);
			while (txq_valid_o !== 1'b1) @(negedge clk_i);
			chk(32'(txq_data_o), 32'(exp_q.pop_front()));
			pulse(P_READY);
		end
		repeat (4) @(posedge clk_i);
		chk(32'(tx_len_o), 32'(n));
		bus(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(32'(rd[IRQ_DONE]), 32'h1);
		$display("test reply len %0d done", n);
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 32'h0);
			chk(rd, 32'h0);
			v = $random(seed);
			bus(1'b1, ofs[i], v);
			bus(1'b0, ofs[i], 32'h0);
			chk(rd, v & msk[i]);
		end
		$display("test register map done");
		reply(15'h0004, 1'b0);
		reply(15'h0183, 1'b1);
		reply(15'h0000, 1'b0);
		bus(1'b1, OFS_TX_SEQ, 32'hFFFF_FF55);
		for (i = 0; i < 2; i++) begin
			@(posedge clk_i);
			ack_valid_i <= 1'b1;
			ack_seq_i   <= 7'h55 ^ 7'(i);
			@(posedge clk_i);
			ack_valid_i <= 1'b0;
			@(negedge clk_i);
			chk(32'(ack_match_o), 32'(i == 0));
		end
		bus(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(32'(rd[IRQ_ACK]), 32'h1);
		$display("test acknowledgement done");
		bus(1'b1, OFS_IRQ_MASK, 32'h200);
		bus(1'b1, OFS_RX_THR, 32'h3);
		pulse(P_START);
		for (i = 1; i <= 5; i++) begin
			pulse(P_BYTE);
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			chk(32'(irq_o), 32'(i == 3 || i == 5));
			bus(1'b0, OFS_RX_CNT, 32'h0);
			chk(rd, 32'(i));
			if (i == 3) begin
				bus(1'b0, OFS_IRQ_STAT, 32'h0);
				chk(32'(rd[IRQ_LVL]), 32'h1);
				bus(1'b1, OFS_RX_THR, 32'h5);
			end
		end
		bus(1'b1, OFS_IRQ_CLR, 32'h200);
		repeat (2) @(posedge clk_i);
		chk(32'(irq_o), 32'h0);
		$display("test receive level done");
		give_verdict();
	end
endmodule // tb_top
